// ---- rtl/kch_top.sv ----
/*
 Keyboard configuration command handler: key types, lamps, repeat timing.
 Assumes a byte framer on the link clock and scan logic on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module kch_top #(
    parameter int TICK_CYC = kch_pkg::TICK_CYC_DF
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             link_clk_i,
    input  wire logic             link_srst_i,
    input  wire logic             rx_valid_i,
    input  wire kch_pkg::kch_rx_t rx_i,
    input  wire logic             tx_ready_i,
    output logic                  tx_valid_o,
    output logic [7:0]            tx_byte_o,
    input  wire logic             scan_enabled_i,
    input  wire logic             code_set3_i,
    output logic                  scan_run_o,
    output logic                  clr_obuf_o,
    output logic                  fwd_valid_o,
    output logic [7:0]            fwd_byte_o,
    output kch_pkg::kch_lamps_t   lamps_o,
    input  wire logic [7:0]       key_code_i,
    output logic [1:0]            key_type_o,
    input  wire logic             rpt_held_i,
    input  wire logic [7:0]       rpt_key_i,
    output logic                  rpt_make_o,
    output logic                  rpt_forget_o
);
    import kch_pkg::*;

    kch_core_t r;
    kch_core_t n;
    kch_link_t l;
    kch_link_t nl;
    logic       rx_ev;
    logic [7:0] rx_b;
    logic       tick;
    logic       rpt_ok;

    // Key type named by a global or per-key command
    function automatic logic [1:0] kt_of(input logic [7:0] c);
        unique case (c)
            CMD_ALL_T, CMD_KEY_T:   kt_of = KT_T;
            CMD_ALL_MB, CMD_KEY_MB: kt_of = KT_MB;
            CMD_ALL_TMB:            kt_of = KT_TMB;
            default:                kt_of = KT_M;
        endcase
    endfunction : kt_of

    // Repeat period in ticks
    function automatic logic [7:0] per_ticks(input logic [6:0] v);
        per_ticks = 8'((RATE_BASE + 8'(v[RATE_A_LSB +: 3])) << v[RATE_B_LSB +: 2]);
    endfunction : per_ticks

    // Initial delay in ticks
    function automatic logic [7:0] dly_ticks(input logic [6:0] v);
        dly_ticks = 8'((8'(v[DLY_LSB +: 2]) + 8'h01) * DELAY_TICKS);
    endfunction : dly_ticks

    assign rx_ev  = r.rx_s2 != r.rx_seen;
    assign rx_b   = l.rx.data;
    assign tick   = r.tick_cnt == 17'(TICK_CYC - 1);
    assign rpt_ok = rpt_held_i && (!code_set3_i || r.ktype[rpt_key_i][KT_RPT_BIT]);

    // Core next state: command decode, key types, lamps, repeat engine
    always_comb begin
        n            = r;
        n.rx_s1      = l.rx_tgl;
        n.rx_s2      = r.rx_s1;
        n.rx_seen    = r.rx_s2;
        n.clr_obuf   = 1'b0;
        n.fwd_valid  = 1'b0;
        n.rpt_make   = 1'b0;
        n.rpt_forget = 1'b0;
        if (rx_ev) begin
            if (l.rx.perr) begin
                n.tx_byte = RSP_RESEND;
                n.tx_tgl  = ~r.tx_tgl;
            end else if (rx_b >= CMD_FIRST) begin
                n.pend    = P_IDLE;
                n.tx_byte = RSP_ACK;
                n.tx_tgl  = ~r.tx_tgl;
                unique case (rx_b)
                    CMD_LED: begin
                        n.pend = P_LED;
                    end
                    CMD_RATE: begin
                        n.pend = P_RATE;
                    end
                    CMD_DFLT, CMD_DDIS: begin
                        n.clr_obuf   = 1'b1;
                        n.ktype      = {256{KT_DFLT}};
                        n.rate       = RATE_DFLT;
                        n.rpt_forget = 1'b1;
                        n.rpt        = R_STOP;
                        n.fwd_valid  = rx_b == CMD_DDIS;
                        n.fwd_byte   = rx_b;
                    end
                    CMD_ALL_T, CMD_ALL_MB, CMD_ALL_M, CMD_ALL_TMB: begin
                        n.clr_obuf = 1'b1;
                        n.ktype    = {256{kt_of(rx_b)}};
                    end
                    CMD_KEY_T, CMD_KEY_MB, CMD_KEY_M: begin
                        n.clr_obuf = 1'b1;
                        n.set_type = kt_of(rx_b);
                        n.pend     = P_KEY;
                    end
                    CMD_INV0, CMD_INV1: begin
                        n.tx_byte = RSP_RESEND;
                    end
                    default: begin
                        // Other commands belong to neighbouring blocks
                        n.tx_tgl    = r.tx_tgl;
                        n.fwd_valid = 1'b1;
                        n.fwd_byte  = rx_b;
                    end
                endcase
            end else begin
                n.tx_byte = RSP_ACK;
                n.tx_tgl  = ~r.tx_tgl;
                unique case (r.pend)
                    P_LED: begin
                        n.lamps = kch_lamps_t'(rx_b[2:0]);
                        n.pend  = P_IDLE;
                    end
                    P_RATE: begin
                        n.rate = rx_b[6:0];
                        n.pend = P_IDLE;
                    end
                    P_KEY: begin
                        n.ktype[rx_b] = r.set_type;
                    end
                    P_IDLE: begin
                        n.tx_byte = RSP_RESEND;
                    end
                endcase
            end
        end
        // Scanning follows the enable except while a lamp or rate value byte is awaited
        n.scan_run = scan_enabled_i && !(n.pend inside {P_LED, P_RATE});
        // Stored types only shape reports in set 3
        n.kt_out = code_set3_i ? r.ktype[key_code_i] : KT_DFLT;
        // Local tick base
        n.tick_cnt = tick ? 17'h00000 : r.tick_cnt + 17'h00001;
        // Repeat engine
        if (!(rx_ev && !l.rx.perr && rx_b inside {CMD_DFLT, CMD_DDIS})) begin
            unique case (r.rpt)
                R_IDLE: begin
                    if (rpt_ok) begin
                        n.rpt     = R_DELAY;
                        n.rpt_key = rpt_key_i;
                        n.rpt_cnt = dly_ticks(r.rate);
                    end
                end
                R_DELAY, R_REPEAT: begin
                    if (!rpt_ok || rpt_key_i != r.rpt_key) begin
                        n.rpt = R_IDLE;
                    end else if (tick) begin
                        if (r.rpt_cnt <= 8'h01) begin
                            n.rpt_make = 1'b1;
                            n.rpt      = R_REPEAT;
                            n.rpt_cnt  = per_ticks(r.rate);
                        end else begin
                            n.rpt_cnt = r.rpt_cnt - 8'h01;
                        end
                    end
                end
                R_STOP: begin
                    if (!rpt_held_i) begin
                        n.rpt = R_IDLE;
                    end
                end
            endcase
        end
    end

    // Core state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r       <= '0;
            r.ktype <= {256{KT_DFLT}};
            r.rate  <= RATE_DFLT;
            r.lamps <= '0;
        end else begin
            r <= n;
        end
    end

    // Link next state: byte capture and response hand-off
    always_comb begin
        nl       = l;
        nl.tx_s1 = r.tx_tgl;
        nl.tx_s2 = l.tx_s1;
        if (rx_valid_i) begin
            nl.rx     = rx_i;
            nl.rx_tgl = ~l.rx_tgl;
        end
        if (l.tx_s2 != l.tx_seen) begin
            // A newer response replaces one not yet taken
            nl.tx_seen  = l.tx_s2;
            nl.tx_valid = 1'b1;
            nl.tx_byte  = r.tx_byte;
        end else if (tx_ready_i) begin
            nl.tx_valid = 1'b0;
        end
    end

    // Link state register
    always_ff @(posedge link_clk_i) begin
        if (link_srst_i) begin
            l <= '0;
        end else begin
            l <= nl;
        end
    end

    assign tx_valid_o   = l.tx_valid;
    assign tx_byte_o    = l.tx_byte;
    assign scan_run_o   = r.scan_run;
    assign clr_obuf_o   = r.clr_obuf;
    assign fwd_valid_o  = r.fwd_valid;
    assign fwd_byte_o   = r.fwd_byte;
    assign lamps_o      = r.lamps;
    assign key_type_o   = r.kt_out;
    assign rpt_make_o   = r.rpt_make;
    assign rpt_forget_o = r.rpt_forget;

    // Checks
    sequence s_cmd(logic [7:0] c);
        rx_ev && !l.rx.perr && rx_b == c;
    endsequence

    sequence s_param(kch_pend_t p);
        rx_ev && !l.rx.perr && rx_b < CMD_FIRST && r.pend == p;
    endsequence

    a_lamps_off: assert property (@(posedge clk_i)
        $fell(srst_i) |-> lamps_o == '0)
        else $error("lamps not off after reset");

    a_led_wait: assert property (@(posedge clk_i) disable iff (srst_i)
        s_cmd(CMD_LED) |=> r.pend == P_LED && !scan_run_o && r.tx_byte == RSP_ACK)
        else $error("indicator command not awaiting option");

    a_led_set: assert property (@(posedge clk_i) disable iff (srst_i)
        s_param(P_LED) |=> lamps_o == $past(rx_b[2:0]) && r.pend == P_IDLE)
        else $error("lamps not set from option byte");

    a_led_abort: assert property (@(posedge clk_i) disable iff (srst_i)
        (rx_ev && rx_b >= CMD_FIRST && r.pend == P_LED) |=> $stable(lamps_o))
        else $error("abandoned indicator command changed lamps");

    a_dflt_lamps: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_cmd(CMD_DFLT) or s_cmd(CMD_DDIS)) |=> $stable(lamps_o) && r.rate == RATE_DFLT)
        else $error("default command touched lamps or missed timing");

    a_rate_keep: assert property (@(posedge clk_i) disable iff (srst_i)
        (rx_ev && rx_b >= CMD_FIRST && r.pend == P_RATE && rx_b != CMD_DFLT
         && rx_b != CMD_DDIS) |=> $stable(r.rate))
        else $error("abandoned timing command changed rate");

    a_rate_load: assert property (@(posedge clk_i) disable iff (srst_i)
        s_param(P_RATE) |=> r.rate == $past(rx_b[6:0]) && r.tx_byte == RSP_ACK)
        else $error("value byte not loaded");

    a_all_keys: assert property (@(posedge clk_i) disable iff (srst_i)
        s_cmd(CMD_ALL_M) |=> r.ktype[0] == KT_M && r.ktype[255] == KT_M && clr_obuf_o)
        else $error("set all keys make-only failed");

    a_resend_perr: assert property (@(posedge clk_i) disable iff (srst_i)
        (rx_ev && l.rx.perr) |=> r.tx_byte == RSP_RESEND && r.tx_tgl != $past(r.tx_tgl))
        else $error("parity error not answered with resend");

    a_rpt_single: assert property (@(posedge clk_i) disable iff (srst_i)
        rpt_make_o |=> !rpt_make_o [*8])
        else $error("repeat codes closer than one period");

    a_rpt_type: assert property (@(posedge clk_i) disable iff (srst_i)
        (code_set3_i && r.rpt == R_IDLE && rpt_held_i
         && r.ktype[rpt_key_i][KT_RPT_BIT] == 1'b0) |=> r.rpt != R_DELAY)
        else $error("non-repeating key started repeat in set 3");
endmodule : kch_top
`default_nettype wire

// ---- include/kch_pkg.sv ----
/*
 Constants and types of the keyboard configuration command handler.
 Assumes the framer delivers whole bytes and a parity flag.
*/
package kch_pkg;
    // Command and response bytes
    localparam logic [7:0] CMD_FIRST   = 8'hed;
    localparam logic [7:0] CMD_LED     = 8'hed;
    localparam logic [7:0] CMD_INV0    = 8'hef;
    localparam logic [7:0] CMD_INV1    = 8'hf1;
    localparam logic [7:0] CMD_RATE    = 8'hf3;
    localparam logic [7:0] CMD_DDIS    = 8'hf5;
    localparam logic [7:0] CMD_DFLT    = 8'hf6;
    localparam logic [7:0] CMD_ALL_T   = 8'hf7;
    localparam logic [7:0] CMD_ALL_MB  = 8'hf8;
    localparam logic [7:0] CMD_ALL_M   = 8'hf9;
    localparam logic [7:0] CMD_ALL_TMB = 8'hfa;
    localparam logic [7:0] CMD_KEY_T   = 8'hfb;
    localparam logic [7:0] CMD_KEY_MB  = 8'hfc;
    localparam logic [7:0] CMD_KEY_M   = 8'hfd;
    localparam logic [7:0] RSP_ACK     = 8'hfa;
    localparam logic [7:0] RSP_RESEND  = 8'hfe;
    // Key types: bit 0 repeats, bit 1 sends break
    localparam logic [1:0] KT_M        = 2'h0;
    localparam logic [1:0] KT_T        = 2'h1;
    localparam logic [1:0] KT_MB       = 2'h2;
    localparam logic [1:0] KT_TMB      = 2'h3;
    localparam logic [1:0] KT_DFLT     = 2'h3;
    localparam int         KT_RPT_BIT  = 0;
    // Value byte fields and defaults
    localparam int         RATE_A_LSB  = 0;
    localparam int         RATE_B_LSB  = 3;
    localparam int         DLY_LSB     = 5;
    localparam logic [6:0] RATE_DFLT   = 7'h2b;
    localparam logic [7:0] RATE_BASE   = 8'h08;
    // Timing
    localparam int         CLK_NS      = 50;
    localparam int         TICK_NS     = 4_170_000;
    localparam int         TICK_CYC_DF = TICK_NS / CLK_NS;
    localparam int         DELAY_MS    = 250;
    localparam logic [7:0] DELAY_TICKS =
        8'((DELAY_MS * 1_000_000) / TICK_NS);

    typedef enum logic [1:0] {P_IDLE, P_LED, P_RATE, P_KEY} kch_pend_t;
    typedef enum logic [1:0] {R_IDLE, R_DELAY, R_REPEAT, R_STOP} kch_rpt_t;

    typedef struct packed {
        logic       perr;
        logic [7:0] data;
    } kch_rx_t;

    typedef struct packed {
        logic caps;
        logic num;
        logic scrl;
    } kch_lamps_t;

    typedef struct packed {
        kch_pend_t        pend;
        logic [1:0]       set_type;
        kch_lamps_t       lamps;
        logic [6:0]       rate;
        logic [255:0][1:0] ktype;
        logic             rx_s1;
        logic             rx_s2;
        logic             rx_seen;
        logic             tx_tgl;
        logic [7:0]       tx_byte;
        logic [1:0]       kt_out;
        logic             clr_obuf;
        logic             scan_run;
        logic             fwd_valid;
        logic [7:0]       fwd_byte;
        kch_rpt_t         rpt;
        logic [7:0]       rpt_key;
        logic [16:0]      tick_cnt;
        logic [7:0]       rpt_cnt;
        logic             rpt_make;
        logic             rpt_forget;
    } kch_core_t;

    typedef struct packed {
        logic       rx_tgl;
        kch_rx_t    rx;
        logic       tx_s1;
        logic       tx_s2;
        logic       tx_seen;
        logic       tx_valid;
        logic [7:0] tx_byte;
    } kch_link_t;
endpackage : kch_pkg

// ---- dv/kch_host_model.sv ----
/*
 Host keyboard controller model: sends bytes and takes response bytes.
 Assumes the link clock of the handler and a caller in the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module kch_host_model (
    input  wire logic        link_clk_i,
    input  wire logic        stall_i,
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_byte_i,
    output logic             rx_valid_o,
    output kch_pkg::kch_rx_t rx_o,
    output logic             tx_ready_o
);
    import kch_pkg::*;
    logic [7:0] rsp_q [$];
    logic [3:0] slot;
    // Idle link at time zero
    initial begin
        rx_valid_o = 1'b0;
        rx_o = '0;
        tx_ready_o = 1'b0;
        slot = 4'h0;
    end
    // One byte; data goes stale once the strobe drops
    task automatic send_byte(input logic [7:0] b, input logic perr);
        @(posedge link_clk_i);
        #1;
        rx_o = '{perr: perr, data: b};
        rx_valid_o = 1'b1;
        @(posedge link_clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_o = ~rx_o;
    endtask : send_byte
    // Take responses promptly, or every sixteenth cycle when stalled
    always @(posedge link_clk_i) begin
        if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) rsp_q.push_back(tx_byte_i);
        slot = slot + 4'h1;
        #1 tx_ready_o = !stall_i || slot == 4'h0;
    end
endmodule : kch_host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
 Testbench of the keyboard configuration command handler.
 Assumes the host model and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import kch_pkg::*;
    localparam int TCK = 16;
    logic       clk_i, link_clk_i, srst_i, stall, rx_valid_i, tx_ready_i, tx_valid_o;
    logic       scan_enabled_i, code_set3_i, scan_run_o, clr_obuf_o, fwd_valid_o;
    logic       rpt_held_i, rpt_make_o, rpt_forget_o;
    kch_rx_t    rx_i;
    logic [7:0] tx_byte_o, fwd_byte_o, key_code_i, rpt_key_i, fwd_last;
    logic [1:0] key_type_o;
    logic [1:0] gt [4];
    kch_lamps_t lamps_o;
    int         error_cnt = 0, num_checks = 0, clr_cnt = 0, i, c;
    int         fgt_cnt = 0, mk_cnt = 0;
    // Core and link clocks, unrelated in phase
    initial begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        link_clk_i = 0;
        #7;
        forever #6 link_clk_i = ~link_clk_i;
    end
    kch_top #(.TICK_CYC(TCK)) kch_top_inst (.clk_i(clk_i), .srst_i(srst_i),
        .link_clk_i(link_clk_i), .link_srst_i(srst_i), .rx_valid_i(rx_valid_i),
        .rx_i(rx_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
        .tx_byte_o(tx_byte_o), .scan_enabled_i(scan_enabled_i),
        .code_set3_i(code_set3_i), .scan_run_o(scan_run_o), .clr_obuf_o(clr_obuf_o),
        .fwd_valid_o(fwd_valid_o), .fwd_byte_o(fwd_byte_o), .lamps_o(lamps_o),
        .key_code_i(key_code_i), .key_type_o(key_type_o), .rpt_held_i(rpt_held_i),
        .rpt_key_i(rpt_key_i), .rpt_make_o(rpt_make_o), .rpt_forget_o(rpt_forget_o));
    kch_host_model kch_host_model_inst (.link_clk_i(link_clk_i), .stall_i(stall),
        .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .rx_valid_o(rx_valid_i),
        .rx_o(rx_i), .tx_ready_o(tx_ready_i));
    // Count buffer clears, keep the last forwarded command
    always @(posedge clk_i) begin
        if (clr_obuf_o === 1'b1) clr_cnt++;
        if (rpt_forget_o === 1'b1) fgt_cnt++;
        if (rpt_make_o === 1'b1) mk_cnt++;
        if (fwd_valid_o === 1'b1) fwd_last = fwd_byte_o;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : tick
    // Send one byte and compare the response
    task automatic cmd(input logic [7:0] b, input logic perr, input logic [7:0] exp);
        int k;
        kch_host_model_inst.send_byte(b, perr);
        for (k = 0; k < 400 && kch_host_model_inst.rsp_q.size() == 0; k++) tick(1);
        if (kch_host_model_inst.rsp_q.size() == 0) chk(8'hxx, exp);
        else chk(kch_host_model_inst.rsp_q.pop_front(), exp);
        tick(4);
    endtask : cmd
    task automatic key_chk(input logic [7:0] code, input logic [1:0] exp);
        key_code_i = code;
        tick(2);
        chk({6'h0, key_type_o}, {6'h0, exp});
    endtask : key_chk
    // Hold the key; measure first delay (20 percent) and one period
    task automatic rpt_chk(input int d, input int per);
        int n;
        int m;
        rpt_held_i = 1'b1;
        for (n = 1; n < 8000 && rpt_make_o !== 1'b1; n++) tick(1);
        chk_rng(n, (d + 1) * 47 * TCK, (d + 1) * 72 * TCK + TCK);
        tick(1);
        for (m = 1; m < 4000 && rpt_make_o !== 1'b1; m++) tick(1);
        chk_rng(m, (per - 1) * TCK, (per + 1) * TCK);
        rpt_held_i = 1'b0;
        tick(4);
    endtask : rpt_chk
    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    initial begin
        #3_000_000;
        error_cnt++;
        finish_test();
    end
    // Main sequence
    initial begin
        srst_i = 1; stall = 0; scan_enabled_i = 1; code_set3_i = 1;
        key_code_i = 8'h1c; rpt_held_i = 0; rpt_key_i = 8'h1c; fwd_last = 8'h00;
        gt = '{KT_T, KT_MB, KT_M, KT_TMB};
        tick(8);
        srst_i = 0;
        tick(3);
        chk({5'h0, lamps_o}, 8'h00);
        key_chk(8'h1c, KT_DFLT);
        chk({7'h0, scan_run_o}, 8'h01);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            cmd(CMD_LED, 0, RSP_ACK);
            chk({7'h0, scan_run_o}, 8'h00);
            cmd(8'(i), 0, RSP_ACK);
            chk({5'h0, lamps_o}, 8'(i));
            chk({7'h0, scan_run_o}, 8'h01);
        end
        c = clr_cnt;
        cmd(CMD_LED, 0, RSP_ACK);
        cmd(CMD_DFLT, 0, RSP_ACK);
        chk({5'h0, lamps_o}, 8'h07);
        chk(8'(clr_cnt - c), 8'h01);
        chk({7'h0, scan_run_o}, 8'h01);
        cmd(CMD_DDIS, 0, RSP_ACK);
        chk({5'h0, lamps_o}, 8'h07);
        chk(fwd_last, CMD_DDIS);
        scan_enabled_i = 0;
        cmd(CMD_LED, 0, RSP_ACK);
        cmd(8'h00, 0, RSP_ACK);
        chk({5'h0, lamps_o, scan_run_o}, 8'h00);
        scan_enabled_i = 1;
        $display("test lamps done");
        cmd(CMD_INV0, 0, RSP_RESEND);
        cmd(CMD_INV1, 0, RSP_RESEND);
        cmd(CMD_LED, 1, RSP_RESEND);
        cmd(8'h10, 0, RSP_RESEND);
        $display("test invalid done");
        for (i = 0; i < 4; i++) begin
            c = clr_cnt;
            cmd(CMD_ALL_T + 8'(i), 0, RSP_ACK);
            chk(8'(clr_cnt - c), 8'h01);
            key_chk(8'h1c, gt[i]);
            key_chk(8'h76, gt[i]);
        end
        code_set3_i = 0;
        cmd(CMD_ALL_M, 0, RSP_ACK);
        key_chk(8'h1c, KT_DFLT);
        code_set3_i = 1;
        key_chk(8'h1c, KT_M);
        $display("test global types done");
        stall = 1;
        cmd(CMD_ALL_TMB, 0, RSP_ACK);
        c = clr_cnt;
        cmd(CMD_KEY_M, 0, RSP_ACK);
        chk(8'(clr_cnt - c), 8'h01);
        cmd(8'h1c, 0, RSP_ACK);
        cmd(8'h76, 0, RSP_ACK);
        cmd(CMD_KEY_MB, 0, RSP_ACK);
        cmd(8'h15, 0, RSP_ACK);
        key_chk(8'h1c, KT_M);
        key_chk(8'h76, KT_M);
        key_chk(8'h15, KT_MB);
        key_chk(8'h2d, KT_TMB);
        cmd(CMD_KEY_T, 0, RSP_ACK);
        cmd(CMD_LED, 0, RSP_ACK);
        cmd(8'h04, 0, RSP_ACK);
        key_chk(8'h04, KT_TMB);
        chk({5'h0, lamps_o}, 8'h04);
        stall = 0;
        $display("test key types done");
        c = fgt_cnt;
        cmd(CMD_DFLT, 0, RSP_ACK);
        chk(8'(fgt_cnt - c), 8'h01);
        key_chk(8'h1c, KT_DFLT);
        rpt_chk(1, 22);
        cmd(CMD_RATE, 0, RSP_ACK);
        chk({7'h0, scan_run_o}, 8'h00);
        cmd(8'h00, 0, RSP_ACK);
        chk({7'h0, scan_run_o}, 8'h01);
        rpt_chk(0, 8);
        cmd(CMD_RATE, 0, RSP_ACK);
        cmd(CMD_LED, 0, RSP_ACK);
        cmd(8'h00, 0, RSP_ACK);
        rpt_chk(0, 8);
        cmd(CMD_RATE, 0, RSP_ACK);
        cmd(8'h7f, 0, RSP_ACK);
        rpt_chk(3, 120);
        // Make-only key must not repeat in set 3, but does outside set 3
        cmd(CMD_RATE, 0, RSP_ACK);
        cmd(8'h00, 0, RSP_ACK);
        cmd(CMD_KEY_M, 0, RSP_ACK);
        cmd(8'h1c, 0, RSP_ACK);
        c = mk_cnt;
        rpt_held_i = 1'b1;
        tick(1200);
        rpt_held_i = 1'b0;
        tick(4);
        chk(8'(mk_cnt - c), 8'h00);
        code_set3_i = 0;
        rpt_chk(0, 8);
        code_set3_i = 1;
        $display("test repeat done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
